/* File: air_adc_input_routing_regs.sv */
`timescale 1ns/1ps
// Operation
// - Second line bit 7 selects differential input
// - Codes 0000-1000 attenuate and connect input
// - Code 1111 disconnects; it is reset value
// - Bit 2 enables weak common-mode bias
// - Second line bits 1:0 read zero
// - First right bit 7 selects differential, resets 0
// - First right level coding matches second line
// - First right bits 2:0 read zero
// - First line left bit 2 powers ADC
module air_adc_input_routing_regs
    import air_pkg::*;
(
    input  wire logic        aclk,                  // Clock, 100 MHz
    input  wire logic        aresetn,               // Synchronous reset, active low
    input  wire logic [7:0]  awaddr,                // Write address
    input  wire logic [2:0]  awprot,                // Write protection, unused
    input  wire logic        awvalid,               // Write address valid
    output logic             awready,               // Write address ready
    input  wire logic [31:0] wdata,                 // Write data
    input  wire logic [3:0]  wstrb,                 // Write byte strobes
    input  wire logic        wvalid,                // Write data valid
    output logic             wready,                // Write data ready
    output logic [1:0]       bresp,                 // Write response
    output logic             bvalid,                // Write response valid
    input  wire logic        bready,                // Write response ready
    input  wire logic [7:0]  araddr,                // Read address
    input  wire logic [2:0]  arprot,                // Read protection, unused
    input  wire logic        arvalid,               // Read address valid
    output logic             arready,               // Read address ready
    output logic [31:0]      rdata,                 // Read data
    output logic [1:0]       rresp,                 // Read response
    output logic             rvalid,                // Read data valid
    input  wire logic        rready,                // Read data ready
    output logic             second_line_left_input_config_select, // 1 = differential
    output logic [3:0]       second_line_left_input_level,         // Attenuation code
    output logic             second_line_left_input_connect,       // Joins left mixer
    output logic             first_line_right_input_config_select, // 1 = differential
    output logic [3:0]       first_line_right_input_level,         // Attenuation code
    output logic             first_line_right_input_connect,       // Joins left mixer
    output logic             left_weak_cm_bias_en,                 // Bias unselected inputs
    output logic             left_adc_power_up                     // Left ADC powered
);
    // =================================================================
    // Address decode.
    function automatic logic air_hit(input logic [7:0] addr, input logic [7:0] idx);
        air_hit = (addr[7:2] == idx[5:0]);
    endfunction

    function automatic logic air_mapped(input logic [7:0] addr);
        air_mapped = air_hit(addr, IDX_FIRST_LINE_LEFT) || air_hit(addr, IDX_SECOND_LINE_LEFT)
                  || air_hit(addr, IDX_FIRST_LINE_RIGHT) || air_hit(addr, IDX_ROUTE_STATUS);
    endfunction

    // =================================================================
    // Write channel.
    air_wr_state_t wr_state_ff, nxt_wr_state;
    logic [7:0]    awaddr_ff, wdata_ff;
    logic [1:0]    bresp_ff;
    logic          aw_held_ff, w_held_ff, wstrb0_ff, awready_ff, wready_ff, bvalid_ff;
    logic          aw_take, w_take, do_write, nxt_aw_held, nxt_w_held, nxt_bvalid;
    logic          wr_first_left, wr_second_left, wr_first_right;

    assign aw_take  = awvalid && awready_ff;
    assign w_take   = wvalid && wready_ff;
    assign do_write = aw_held_ff && w_held_ff && (wr_state_ff == AIR_WR_COLLECT);

    always_comb begin
        nxt_aw_held  = (aw_held_ff || aw_take) && !do_write;
        nxt_w_held   = (w_held_ff || w_take) && !do_write;
        nxt_bvalid   = do_write || (bvalid_ff && !bready);
        nxt_wr_state = wr_state_ff;
        case (wr_state_ff)
            AIR_WR_COLLECT: begin
                if (do_write) begin
                    nxt_wr_state = AIR_WR_RESP;
                end
            end
            AIR_WR_RESP: begin
                if (bready) begin
                    nxt_wr_state = AIR_WR_COLLECT;
                end
            end
            default: nxt_wr_state = AIR_WR_COLLECT;
        endcase
    end

    // Address and data are taken independently, so either may lead.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awaddr_ff  <= 8'h00;
            aw_held_ff <= 1'b0;
            awready_ff <= 1'b0;
        end else begin
            if (aw_take) begin
                awaddr_ff <= awaddr;
            end
            aw_held_ff <= nxt_aw_held;
            awready_ff <= !nxt_aw_held && !nxt_bvalid;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wdata_ff  <= 8'h00;
            wstrb0_ff <= 1'b0;
            w_held_ff <= 1'b0;
            wready_ff <= 1'b0;
        end else begin
            if (w_take) begin
                wdata_ff  <= wdata[7:0];
                wstrb0_ff <= wstrb[0];
            end
            w_held_ff <= nxt_w_held;
            wready_ff <= !nxt_w_held && !nxt_bvalid;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wr_state_ff <= AIR_WR_COLLECT;
            bvalid_ff   <= 1'b0;
            bresp_ff    <= RESP_OKAY;
        end else begin
            wr_state_ff <= nxt_wr_state;
            bvalid_ff   <= nxt_bvalid;
            if (do_write) begin
                bresp_ff <= air_mapped(awaddr_ff) ? RESP_OKAY : RESP_SLVERR;
            end
        end
    end

    // Only byte lane 0 carries register bits; other lanes are ignored.
    assign wr_first_left  = do_write && wstrb0_ff && air_hit(awaddr_ff, IDX_FIRST_LINE_LEFT);
    assign wr_second_left = do_write && wstrb0_ff && air_hit(awaddr_ff, IDX_SECOND_LINE_LEFT);
    assign wr_first_right = do_write && wstrb0_ff && air_hit(awaddr_ff, IDX_FIRST_LINE_RIGHT);

    // =================================================================
    // Register bank.
    logic [7:0] first_left_q, second_left_q, first_right_q;
    logic       l2_connect, l2_reserved, l1r_connect, l1r_reserved;

    air_cfg_reg #(.RST_VAL(RST_FIRST_LINE_LEFT), .WR_MASK(MASK_FIRST_LINE_LEFT)) u_first_left (
        .aclk    (aclk),
        .aresetn (aresetn),
        .wr_en   (wr_first_left),
        .wr_data (wdata_ff),
        .q       (first_left_q)
    );

    air_cfg_reg #(.RST_VAL(RST_SECOND_LINE_LEFT), .WR_MASK(MASK_SECOND_LINE_LEFT)) u_second_left (
        .aclk    (aclk),
        .aresetn (aresetn),
        .wr_en   (wr_second_left),
        .wr_data (wdata_ff),
        .q       (second_left_q)
    );

    air_cfg_reg #(.RST_VAL(RST_FIRST_LINE_RIGHT), .WR_MASK(MASK_FIRST_LINE_RIGHT)) u_first_right (
        .aclk    (aclk),
        .aresetn (aresetn),
        .wr_en   (wr_first_right),
        .wr_data (wdata_ff),
        .q       (first_right_q)
    );

    // A reserved code is stored as written but never connects the input.
    air_level_decode u_l2_decode (
        .level_code (second_left_q[LVL_HI:LVL_LO]),
        .connect    (l2_connect),
        .reserved   (l2_reserved)
    );

    air_level_decode u_l1r_decode (
        .level_code (first_right_q[LVL_HI:LVL_LO]),
        .connect    (l1r_connect),
        .reserved   (l1r_reserved)
    );

    // =================================================================
    // Analog control outputs.
    logic       l2_sel_ff, l2_conn_ff, l1r_sel_ff, l1r_conn_ff, bias_ff, power_ff;
    logic [3:0] l2_level_ff, l1r_level_ff;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            l2_sel_ff    <= 1'b0;
            l2_level_ff  <= LVL_DISCONNECT;
            l2_conn_ff   <= 1'b0;
            l1r_sel_ff   <= 1'b0;
            l1r_level_ff <= LVL_DISCONNECT;
            l1r_conn_ff  <= 1'b0;
            bias_ff      <= 1'b0;
            power_ff     <= 1'b0;
        end else begin
            l2_sel_ff    <= second_left_q[CFG_SEL_BIT];
            l2_level_ff  <= second_left_q[LVL_HI:LVL_LO];
            l2_conn_ff   <= l2_connect;
            l1r_sel_ff   <= first_right_q[CFG_SEL_BIT];
            l1r_level_ff <= first_right_q[LVL_HI:LVL_LO];
            l1r_conn_ff  <= l1r_connect;
            bias_ff      <= second_left_q[BIAS_BIT];
            power_ff     <= first_left_q[PWR_BIT];
        end
    end

    // =================================================================
    // Read channel.
    air_rd_state_t rd_state_ff, nxt_rd_state;
    logic          arready_ff, rvalid_ff, ar_take;
    logic [7:0]    rdata_ff, rd_mux, status_val;
    logic [1:0]    rresp_ff;

    assign ar_take = arvalid && arready_ff;

    always_comb begin
        status_val              = 8'h00;
        status_val[ST_L2_CONN]  = l2_connect;
        status_val[ST_L1R_CONN] = l1r_connect;
        status_val[ST_L2_RSVD]  = l2_reserved;
        status_val[ST_L1R_RSVD] = l1r_reserved;
        rd_mux                  = 8'h00;
        if (air_hit(araddr, IDX_FIRST_LINE_LEFT)) begin
            rd_mux = first_left_q;
        end else if (air_hit(araddr, IDX_SECOND_LINE_LEFT)) begin
            rd_mux = second_left_q;
        end else if (air_hit(araddr, IDX_FIRST_LINE_RIGHT)) begin
            rd_mux = first_right_q;
        end else if (air_hit(araddr, IDX_ROUTE_STATUS)) begin
            rd_mux = status_val;
        end
    end

    always_comb begin
        nxt_rd_state = rd_state_ff;
        case (rd_state_ff)
            AIR_RD_IDLE: begin
                if (ar_take) begin
                    nxt_rd_state = AIR_RD_RESP;
                end
            end
            AIR_RD_RESP: begin
                if (rready) begin
                    nxt_rd_state = AIR_RD_IDLE;
                end
            end
            default: nxt_rd_state = AIR_RD_IDLE;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rd_state_ff <= AIR_RD_IDLE;
            arready_ff  <= 1'b0;
            rvalid_ff   <= 1'b0;
            rdata_ff    <= 8'h00;
            rresp_ff    <= RESP_OKAY;
        end else begin
            rd_state_ff <= nxt_rd_state;
            arready_ff  <= (nxt_rd_state == AIR_RD_IDLE);
            rvalid_ff   <= (nxt_rd_state == AIR_RD_RESP);
            if (ar_take) begin
                rdata_ff <= rd_mux;
                rresp_ff <= air_mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
            end
        end
    end

    assign awready = awready_ff;
    assign wready  = wready_ff;
    assign bvalid  = bvalid_ff;
    assign bresp   = bresp_ff;
    assign arready = arready_ff;
    assign rvalid  = rvalid_ff;
    assign rdata   = {24'h000000, rdata_ff};
    assign rresp   = rresp_ff;

    assign second_line_left_input_config_select = l2_sel_ff;
    assign second_line_left_input_level         = l2_level_ff;
    assign second_line_left_input_connect       = l2_conn_ff;
    assign first_line_right_input_config_select = l1r_sel_ff;
    assign first_line_right_input_level         = l1r_level_ff;
    assign first_line_right_input_connect       = l1r_conn_ff;
    assign left_weak_cm_bias_en                 = bias_ff;
    assign left_adc_power_up                    = power_ff;

    // =================================================================
    // Assertions.
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    property p_l2_sel;
        wr_second_left |-> ##2 (l2_sel_ff == $past(wdata_ff[7], 2));
    endproperty
    a_l2_sel: assert property (p_l2_sel) else $error("Config select did not follow write.");
    property p_l2_gain;
        (l2_level_ff <= LVL_MAX_GAIN_CODE) |-> l2_conn_ff;
    endproperty
    a_l2_gain: assert property (p_l2_gain) else $error("Gain code left input unconnected.");
    property p_l2_off;
        (l2_level_ff == LVL_DISCONNECT) |-> !l2_conn_ff;
    endproperty
    a_l2_off: assert property (p_l2_off) else $error("Disconnect code left input connected.");
    property p_bias;
        wr_second_left |=> ##1 (bias_ff == $past(wdata_ff[2], 2));
    endproperty
    a_bias: assert property (p_bias) else $error("Bias enable did not follow write.");
    property p_l2_rsvd;
        (ar_take && air_hit(araddr, IDX_SECOND_LINE_LEFT)) |=> (rdata[1:0] == 2'b00) && rvalid;
    endproperty
    a_l2_rsvd: assert property (p_l2_rsvd) else $error("Reserved bits read nonzero.");
    property p_l1r_sel;
        $changed(first_right_q[7]) |=> (l1r_sel_ff == $past(first_right_q[7]));
    endproperty
    a_l1r_sel: assert property (p_l1r_sel) else $error("Right input select lagging.");
    property p_l1r_conn;
        (first_right_q[6:3] == LVL_DISCONNECT) [*2] |-> !l1r_conn_ff;
    endproperty
    a_l1r_conn: assert property (p_l1r_conn) else $error("Right input connected when off.");
    property p_l1r_rsvd;
        (ar_take && air_hit(araddr, IDX_FIRST_LINE_RIGHT)) |=> (rdata[2:0] == 3'b000);
    endproperty
    a_l1r_rsvd: assert property (p_l1r_rsvd) else $error("Reserved bits read nonzero.");
    // The register takes the byte one edge after the strobe and the pin follows one edge later.
    property p_power;
        wr_first_left |=> ##1 (power_ff == $past(wdata_ff[2], 2));
    endproperty
    a_power: assert property (p_power) else $error("Power control did not follow write.");
    property p_readback;
        (ar_take && air_hit(araddr, IDX_SECOND_LINE_LEFT)) |=> (rdata[7:2] == $past(second_left_q[7:2]));
    endproperty
    a_readback: assert property (p_readback) else $error("Readback mismatch.");

endmodule // air_adc_input_routing_regs

/* File: air_cfg_reg.sv */
`timescale 1ns/1ps
// =====================================================================
// Eight-bit control register; bits outside the mask keep their reset value.
module air_cfg_reg
    import air_pkg::*;
#(
    parameter logic [7:0] RST_VAL = 8'h00,
    parameter logic [7:0] WR_MASK = 8'hff
)(
    input  wire logic       aclk,    // Bus clock
    input  wire logic       aresetn, // Synchronous reset, active low
    input  wire logic       wr_en,   // Write strobe, one cycle
    input  wire logic [7:0] wr_data, // Byte written by software
    output logic      [7:0] q        // Current register value
);
    logic [7:0] q_ff;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q_ff <= RST_VAL;
        end else if (wr_en) begin
            q_ff <= (wr_data & WR_MASK) | (RST_VAL & ~WR_MASK);
        end
    end

    assign q = q_ff;
endmodule // air_cfg_reg

/* File: air_level_decode.sv */
`timescale 1ns/1ps
// =====================================================================
// Level code decoder: a gain code connects the input to the mixer.
module air_level_decode
    import air_pkg::*;
(
    input  wire logic [3:0] level_code, // Attenuation code from the register
    output logic            connect,    // Input joins the left mixer
    output logic            reserved    // Code lies in the reserved gap
);
    always_comb begin
        connect  = (level_code <= LVL_MAX_GAIN_CODE);
        reserved = (level_code > LVL_MAX_GAIN_CODE) && (level_code != LVL_DISCONNECT);
    end
endmodule // air_level_decode

/* File: air_pkg.sv */
// =====================================================================
// Shared constants for the left ADC input routing register bank.
package air_pkg;

    // =================================================================
    // Register indices; the byte address is four times the index.
    localparam logic [7:0] IDX_FIRST_LINE_LEFT = 8'h13;
    localparam logic [7:0] IDX_SECOND_LINE_LEFT = 8'h14;
    localparam logic [7:0] IDX_FIRST_LINE_RIGHT = 8'h15;
    localparam logic [7:0] IDX_ROUTE_STATUS = 8'h18;

    localparam logic [7:0] ADDR_FIRST_LINE_LEFT = {IDX_FIRST_LINE_LEFT[5:0], 2'b00};
    localparam logic [7:0] ADDR_SECOND_LINE_LEFT = {IDX_SECOND_LINE_LEFT[5:0], 2'b00};
    localparam logic [7:0] ADDR_FIRST_LINE_RIGHT = {IDX_FIRST_LINE_RIGHT[5:0], 2'b00};
    localparam logic [7:0] ADDR_ROUTE_STATUS = {IDX_ROUTE_STATUS[5:0], 2'b00};

    // =================================================================
    // Field positions.
    localparam int unsigned CFG_SEL_BIT = 7;
    localparam int unsigned LVL_HI = 6;
    localparam int unsigned LVL_LO = 3;
    localparam int unsigned BIAS_BIT = 2;
    localparam int unsigned PWR_BIT = 2;
    localparam int unsigned ST_L2_CONN = 0;
    localparam int unsigned ST_L1R_CONN = 1;
    localparam int unsigned ST_L2_RSVD = 2;
    localparam int unsigned ST_L1R_RSVD = 3;

    // =================================================================
    // Reset values and writable-bit masks.
    localparam logic [7:0] RST_SECOND_LINE_LEFT = 8'h78;
    localparam logic [7:0] RST_FIRST_LINE_RIGHT = 8'h78;
    localparam logic [7:0] RST_FIRST_LINE_LEFT = 8'h00;
    localparam logic [7:0] MASK_SECOND_LINE_LEFT = 8'hfc;
    localparam logic [7:0] MASK_FIRST_LINE_RIGHT = 8'hf8;
    localparam logic [7:0] MASK_FIRST_LINE_LEFT = 8'h04;

    // =================================================================
    // Level codes and bus responses.
    localparam logic [3:0] LVL_MAX_GAIN_CODE = 4'h8;
    localparam logic [3:0] LVL_DISCONNECT = 4'hf;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic {
        AIR_WR_COLLECT,
        AIR_WR_RESP
    } air_wr_state_t;

    typedef enum logic {
        AIR_RD_IDLE,
        AIR_RD_RESP
    } air_rd_state_t;

endpackage

/* File: tb.sv */
`timescale 1ns/1ps
module tb
    import air_pkg::*;
();
    logic        aclk    = 1'b0;
    logic        aresetn = 1'b0;
    logic [7:0]  awaddr  = 8'h00;
    logic        awvalid = 1'b0;
    logic [31:0] wdata   = 32'h0;
    logic [3:0]  wstrb   = 4'h0;
    logic        wvalid  = 1'b0;
    logic        bready  = 1'b0;
    logic [7:0]  araddr  = 8'h00;
    logic        arvalid = 1'b0;
    logic        rready  = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [1:0]  bresp, rresp;
    logic [31:0] rdata;
    logic        l2_sel, l2_conn, r1_sel, r1_conn, bias_en, pwr_up;
    logic [3:0]  l2_lvl, r1_lvl;
    logic [1:0]  resp;
    logic [31:0] val;
    int          fails     = 0;
    int          num_checks = 0;

    air_adc_input_routing_regs dut_u (
        .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(3'h0),
        .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
        .rready(rready),
        .second_line_left_input_config_select(l2_sel), .second_line_left_input_level(l2_lvl),
        .second_line_left_input_connect(l2_conn), .first_line_right_input_config_select(r1_sel),
        .first_line_right_input_level(r1_lvl), .first_line_right_input_connect(r1_conn),
        .left_weak_cm_bias_en(bias_en), .left_adc_power_up(pwr_up)
    );

    always #5 aclk = ~aclk;

    // =================================================================
    // Bus master and comparison.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Each channel is released at the edge that takes it; the task sees pre-edge values.
    // A hung bus is left to the watchdog; one idle edge after each transfer keeps
    // the next call from driving bready or rready twice in one time step.
    task automatic axi_wr(input logic [7:0] a, input logic [7:0] d, input logic [3:0] s);
        awaddr  <= a;
        wdata   <= {24'h0, d};
        wstrb   <= s;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        forever begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid && bready) break;
        end
        resp = bresp;
        bready <= 1'b0;
        @(posedge aclk);
    endtask

    task automatic axi_rd(input logic [7:0] a);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        forever begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid && rready) break;
        end
        resp = rresp;
        val  = rdata;
        rready <= 1'b0;
        @(posedge aclk);
    endtask

    // Outputs settle at the edge that completes the response handshake.
    task automatic settle();
        @(posedge aclk);
    endtask

    // =================================================================
    // Scenarios.
    task automatic t_reset();
        axi_rd(ADDR_SECOND_LINE_LEFT);
        chk(val, 32'h78);
        axi_rd(ADDR_FIRST_LINE_RIGHT);
        chk(val, 32'h78);
        axi_rd(ADDR_FIRST_LINE_LEFT);
        chk(val, 32'h00);
        chk({26'h0, l2_sel, r1_sel, l2_conn, r1_conn, bias_en, pwr_up}, 32'h0);
        chk({24'h0, l2_lvl, r1_lvl}, 32'hff);
    endtask

    task automatic t_all_ones();
        axi_wr(ADDR_SECOND_LINE_LEFT, 8'hff, 4'h1);
        axi_wr(ADDR_FIRST_LINE_RIGHT, 8'hff, 4'h1);
        settle();
        chk({29'h0, l2_sel, bias_en, l2_conn}, 32'h6);
        chk({30'h0, r1_sel, r1_conn}, 32'h2);
        axi_rd(ADDR_SECOND_LINE_LEFT);
        chk(val, 32'hfc);
        axi_rd(ADDR_FIRST_LINE_RIGHT);
        chk(val, 32'hf8);
    endtask

    // Only the gain codes and the disconnect code are ever written here.
    task automatic t_levels();
        logic [3:0] c;
        for (int i = 0; i <= 8; i++) begin
            c = i[3:0];
            axi_wr(ADDR_SECOND_LINE_LEFT, {1'b0, c, 3'b000}, 4'h1);
            axi_wr(ADDR_FIRST_LINE_RIGHT, {1'b0, c, 3'b000}, 4'h1);
            settle();
            chk({24'h0, l2_lvl, r1_lvl}, {24'h0, c, c});
            chk({30'h0, l2_conn, r1_conn}, 32'h3);
            chk({30'h0, l2_sel, bias_en}, 32'h0);
            axi_rd(ADDR_SECOND_LINE_LEFT);
            chk(val, {25'h0, c, 3'b000});
            axi_rd(ADDR_ROUTE_STATUS);
            chk(val, 32'h3);
        end
        axi_wr(ADDR_SECOND_LINE_LEFT, 8'h78, 4'h1);
        settle();
        chk({30'h0, l2_conn, r1_conn}, 32'h1);
        axi_wr(ADDR_FIRST_LINE_RIGHT, 8'h78, 4'h1);
        settle();
        chk({30'h0, l2_conn, r1_conn}, 32'h0);
        axi_rd(ADDR_ROUTE_STATUS);
        chk(val, 32'h0);
    endtask

    task automatic t_power();
        axi_wr(ADDR_FIRST_LINE_LEFT, 8'hff, 4'h1);
        settle();
        chk({31'h0, pwr_up}, 32'h1);
        axi_rd(ADDR_FIRST_LINE_LEFT);
        chk(val, 32'h04);
        axi_wr(ADDR_FIRST_LINE_LEFT, 8'h00, 4'h1);
        settle();
        chk({30'h0, pwr_up, bias_en}, 32'h0);
    endtask

    task automatic t_refused();
        axi_wr(8'h40, 8'hff, 4'h1);
        chk({30'h0, resp}, {30'h0, RESP_SLVERR});
        axi_rd(8'h40);
        chk({30'h0, resp}, {30'h0, RESP_SLVERR});
        chk(val, 32'h0);
        axi_wr(ADDR_SECOND_LINE_LEFT, 8'h84, 4'h0);
        chk({30'h0, resp}, {30'h0, RESP_OKAY});
        axi_rd(ADDR_SECOND_LINE_LEFT);
        chk(val, 32'h78);
    endtask

    // =================================================================
    // Closing and sequencing.
    task automatic report_and_stop();
        $display("checks=%0d mismatches=%0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    initial begin
        #200us;
        fails++;
        report_and_stop();
    end

    initial begin
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset();
        t_all_ones();
        t_levels();
        t_power();
        t_refused();
        report_and_stop();
    end
endmodule // tb
